// >>> logic/asa_params.svh
/*
 Constants of the alarm status aggregator: sizes, register offsets,
 field positions, reset values, loop state codes and timing counts.
 Assumes it is included by its bare name from the package only.
*/
`ifndef ASA_PARAMS_SVH
`define ASA_PARAMS_SVH
// source counts; the last loop channel is the system phase loop
`define ASA_N_REF 4
`define ASA_N_LOOP 5
`define ASA_N_ALM (3 * `ASA_N_REF + 2 * `ASA_N_LOOP)
`define ASA_N_BLK (`ASA_N_REF + `ASA_N_LOOP)
`define ASA_N_GPIO 8
`define ASA_PIN_W 3
`define ASA_SEL_W 5
`define ASA_ST_W 3
// register offsets (byte addresses)
`define ASA_REG_CTRL 8'h00
`define ASA_REG_LIVE 8'h04
`define ASA_REG_STICKY 8'h08
`define ASA_REG_STICKY_CLR 8'h0c
`define ASA_REG_ALERT_EN 8'h10
`define ASA_REG_BLK_STICKY 8'h14
`define ASA_REG_BLK_CLR 8'h18
`define ASA_REG_BLK_EN 8'h1c
`define ASA_REG_GPIO_BASE 8'h20
`define ASA_REG_LOOP_STATE 8'h40
`define ASA_REG_ALERT_STAT 8'h44
// control register fields
`define ASA_CTRL_GEN 0
`define ASA_CTRL_AINV 1
`define ASA_CTRL_AON 2
`define ASA_CTRL_APIN_LSB 4
// reset values
`define ASA_CTRL_RST 32'h0000_0000
`define ASA_BLK_EN_RST 32'h0000_01ff
// loop state codes presented by each loop channel
`define ASA_LS_HOLDOVER 3'h4
`define ASA_LS_LOCKED 3'h3
// alert release hold: time in ns and derived cycles (round down)
`define ASA_RELEASE_NS 200000
`define ASA_CLK_NS 50
`define ASA_RELEASE_CYC (`ASA_RELEASE_NS / `ASA_CLK_NS)
`define ASA_CNT_W 12
`endif

// >>> logic/asa_pkg.sv
/*
 Types shared by the aggregator modules.
 Assumes asa_params.svh is on the include path.
*/
`include "asa_params.svh"
package asa_pkg;
    typedef logic [`ASA_N_ALM-1:0] asa_alm_t;
    typedef logic [`ASA_N_BLK-1:0] asa_blk_t;
    typedef struct packed {
        logic en;
        logic inv;
        logic sticky;
        logic [`ASA_SEL_W-1:0] sel;
    } asa_gpio_cfg_s;
    typedef asa_gpio_cfg_s [`ASA_N_GPIO-1:0] asa_cfg_arr_t;
    typedef struct packed {
        asa_alm_t prev;
        asa_alm_t sticky;
        asa_blk_t blk;
    } asa_bank_s;
    typedef struct packed {
        logic [`ASA_N_GPIO-1:0] gpio;
        logic [`ASA_N_GPIO-1:0] oe;
        logic [`ASA_CNT_W-1:0] hold;
        logic alert;
    } asa_pin_s;
    // owning block of alarm i: freq, los, activity per reference,
    // then holdover and lock per loop channel
    function automatic int asa_alm_block(input int i);
        if (i < 3 * `ASA_N_REF)
            return i % `ASA_N_REF;
        return `ASA_N_REF + ((i - 3 * `ASA_N_REF) % `ASA_N_LOOP);
    endfunction
endpackage

// >>> logic/asa_alarm_if.sv
/*
 Alarm bundle between register front end, sticky bank and pin drive.
 Assumes one clock domain shared by all users.
*/
`timescale 1ns/10ps
`default_nettype none
interface asa_alarm_if;
    import asa_pkg::*;
    asa_alm_t live;
    asa_alm_t sticky;
    asa_alm_t sticky_clr;
    asa_blk_t blk_sticky;
    asa_blk_t blk_clr;
    logic glob_en;
    modport bank(input live, sticky_clr, blk_clr, glob_en,
                 output sticky, blk_sticky);
    modport pins(input live, sticky, blk_sticky);
    modport ctl(output live, sticky_clr, blk_clr, glob_en,
                input sticky, blk_sticky);
endinterface
`default_nettype wire

// >>> logic/asa_sticky_bank.sv
/*
 Sticky change bits per alarm plus block-level sticky bits.
 Assumes clear vectors are single-cycle write-one pulses.
*/
`timescale 1ns/10ps
`default_nettype none
module asa_sticky_bank (
    input wire logic i_clk,
    input wire logic i_srst,
    asa_alarm_if.bank bus,
    input wire asa_pkg::asa_blk_t i_blk_en
);
    import asa_pkg::*;
    asa_bank_s st;
    asa_bank_s next_st;

    // edge detect on live bits, set beats clear, block follows members
    always_comb
    begin
        logic any;
        any = 1'b0;
        next_st = st;
        next_st.prev = bus.live;
        for (int i = 0; i < `ASA_N_ALM; i++)
        begin
            next_st.sticky[i] = (st.sticky[i] & ~bus.sticky_clr[i]) |
                (bus.glob_en & i_blk_en[asa_alm_block(i)] &
                 (bus.live[i] ^ st.prev[i]));
        end
        for (int b = 0; b < `ASA_N_BLK; b++)
        begin
            any = 1'b0;
            for (int i = 0; i < `ASA_N_ALM; i++)
                if (asa_alm_block(i) == b)
                    any = any | next_st.sticky[i];
            next_st.blk[b] = (st.blk[b] & ~bus.blk_clr[b]) | any;
        end
    end

    // state register
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
            st <= '0;
        else
            st <= next_st;
    end

    assign bus.sticky = st.sticky;
    assign bus.blk_sticky = st.blk;
endmodule
`default_nettype wire

// >>> logic/asa_pin_drive.sv
/*
 Drives general-purpose pins with single alarms or the alert output.
 Assumes configuration is stable registers from the front end.
*/
`timescale 1ns/10ps
`default_nettype none
module asa_pin_drive (
    input wire logic i_clk,
    input wire logic i_srst,
    asa_alarm_if.pins bus,
    input wire asa_pkg::asa_alm_t i_alert_en,
    input wire asa_pkg::asa_cfg_arr_t i_cfg,
    input wire logic i_alert_on,
    input wire logic i_alert_inv,
    input wire logic [`ASA_PIN_W-1:0] i_alert_pin,
    output logic [`ASA_N_GPIO-1:0] o_gpio,
    output logic [`ASA_N_GPIO-1:0] o_gpio_oe,
    output logic o_alert
);
    import asa_pkg::*;
    asa_pin_s st;
    asa_pin_s next_st;

    // reference alarms show live; loop alarms live or sticky by config
    function automatic logic pick(input asa_gpio_cfg_s c, input asa_alm_t lv,
                                  input asa_alm_t sk);
        if (int'(c.sel) >= `ASA_N_ALM)
            return 1'b0;
        if (int'(c.sel) < 3 * `ASA_N_REF || !c.sticky)
            return lv[c.sel];
        return sk[c.sel];
    endfunction

    always_comb
    begin
        logic src;
        logic has_en;
        src = |(bus.sticky & i_alert_en);
        has_en = 1'b0;
        next_st = st;
        // block bits hold the alert too, for blocks with enabled members
        for (int b = 0; b < `ASA_N_BLK; b++)
        begin
            has_en = 1'b0;
            for (int i = 0; i < `ASA_N_ALM; i++)
                if (asa_alm_block(i) == b)
                    has_en = has_en | i_alert_en[i];
            src = src | (bus.blk_sticky[b] & has_en);
        end
        // negation lags the last clear by the release hold; the reload
        // leaves room for the alert and pin registers behind the counter
        if (src)
            next_st.hold = `ASA_CNT_W'(`ASA_RELEASE_CYC - 2);
        else if (st.hold != '0)
            next_st.hold = st.hold - `ASA_CNT_W'(1);
        next_st.alert = src | (st.hold != '0);
        for (int g = 0; g < `ASA_N_GPIO; g++)
        begin
            if (i_alert_on && int'(i_alert_pin) == g)
            begin
                next_st.gpio[g] = st.alert ^ i_alert_inv;
                next_st.oe[g] = 1'b1;
            end
            else
            begin
                next_st.gpio[g] = pick(i_cfg[g], bus.live, bus.sticky) ^
                    i_cfg[g].inv;
                next_st.oe[g] = i_cfg[g].en;
            end
        end
    end

    // state register
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
            st <= '0;
        else
            st <= next_st;
    end

    assign o_gpio = st.gpio;
    assign o_gpio_oe = st.oe;
    assign o_alert = st.alert;
endmodule
`default_nettype wire

// >>> logic/asa_top.sv
/*
 Alarm status aggregator top: register port, live alarm derivation,
 sticky bank and pin drive.
 Assumes alarm inputs and loop state codes are synchronous to the core
 clock, and a master that never needs wait states.
*/
// Decided for this implementation: the address map and strobed register access.
`timescale 1ns/10ps
`default_nettype none
// Contract
// - each alarm has a live bit read as its present state
// - each alarm has a sticky bit set on change, held until cleared
// - sticky sets on both rising and falling live transitions
// - single-alarm pin shows live or sticky, high means alarm present; pins on reference alarms show live only
// - single-alarm pin polarity can be inverted
// - alert output is formed from sticky bits only
// - software picks the alert pin and per-alarm contribution
// - alert pin polarity can be inverted
// - holdover live bit follows channel being in holdover state
// - lock live bit needs channel locked and system analogue loop locked
// - sources: reference freq, loss, activity; loop holdover and lock
// - each block has sticky bit, clear bit, controls; loops show state
// - alert stays until individual and block sticky bits are cleared
// - one write clears any single bit, subset or all
// - alert may lag clears up to 200 us; host avoids direct irq
// - a global enable gates all alarm sources
// - loop live bits follow state; sticky on state entry and exit
// - only one pin carries the alert
// - alert is active high by default while enabled stickies set
// - alert holds until every contributing sticky is cleared
module asa_top (
    input wire logic I_CORE_CLK,
    input wire logic I_SRST,
    input wire logic [7:0] I_ADDR,
    input wire logic [31:0] I_WDATA,
    input wire logic I_WR,
    input wire logic I_RD,
    output logic [31:0] O_RDATA,
    input wire logic [`ASA_N_REF-1:0] I_REF_FREQ_ALM,
    input wire logic [`ASA_N_REF-1:0] I_REF_LOS_ALM,
    input wire logic [`ASA_N_REF-1:0] I_REF_ACT_ALM,
    input wire logic [`ASA_N_LOOP*`ASA_ST_W-1:0] I_LOOP_STATE,
    input wire logic I_SYS_APLL_LOCKED,
    output logic [`ASA_N_GPIO-1:0] O_GPIO,
    output logic [`ASA_N_GPIO-1:0] O_GPIO_OE
);
    import asa_pkg::*;

    // software-visible control state and read data
    typedef struct packed {
        logic glob_en;
        logic alert_inv;
        logic alert_on;
        logic [`ASA_PIN_W-1:0] alert_pin;
        asa_alm_t alert_en;
        asa_blk_t blk_en;
        asa_cfg_arr_t cfg;
        logic [31:0] rdata;
    } asa_top_s;

    asa_top_s st;
    asa_top_s next_st;
    asa_alarm_if alm ();
    asa_alm_t live;
    asa_alm_t sticky_clr;
    asa_blk_t blk_clr;
    logic alert;
    logic wr_sticky_clr;
    logic wr_blk_clr;

    // true when the address falls in the per-pin configuration window
    function automatic logic is_gpio(input logic [7:0] a);
        return a[7:5] == 3'h1;
    endfunction

    // pin index of a configuration address
    function automatic int gpio_idx(input logic [7:0] a);
        return int'(a[4:2]);
    endfunction

    // reference monitor alarms pass straight through as live bits
    generate
        for (genvar r = 0; r < `ASA_N_REF; r++)
        begin : g_ref
            assign live[r] = I_REF_FREQ_ALM[r];
            assign live[`ASA_N_REF + r] = I_REF_LOS_ALM[r];
            assign live[2 * `ASA_N_REF + r] = I_REF_ACT_ALM[r];
        end
    endgenerate

    // loop channel live bits decoded from the present state code
    generate
        for (genvar l = 0; l < `ASA_N_LOOP; l++)
        begin : g_loop
            logic [`ASA_ST_W-1:0] code;
            assign code = I_LOOP_STATE[l*`ASA_ST_W +: `ASA_ST_W];
            // holdover tracks the state directly
            assign live[3 * `ASA_N_REF + l] =
                code == `ASA_LS_HOLDOVER;
            // lock also needs the system analogue loop in lock
            assign live[3 * `ASA_N_REF + `ASA_N_LOOP + l] =
                (code == `ASA_LS_LOCKED) & I_SYS_APLL_LOCKED;
        end
    endgenerate

    // clear strobes are pure write pulses; no state is kept for them
    assign wr_sticky_clr = I_WR && I_ADDR == `ASA_REG_STICKY_CLR;
    assign wr_blk_clr = I_WR && I_ADDR == `ASA_REG_BLK_CLR;
    assign sticky_clr = wr_sticky_clr ?
        I_WDATA[`ASA_N_ALM-1:0] : '0;
    assign blk_clr = wr_blk_clr ? I_WDATA[`ASA_N_BLK-1:0] : '0;

    // bundle towards the sticky bank and the pin drive
    assign alm.live = live;
    assign alm.sticky_clr = sticky_clr;
    assign alm.blk_clr = blk_clr;
    assign alm.glob_en = st.glob_en;

    // register writes and the registered read answer
    always_comb
    begin
        logic [31:0] rd;
        rd = 32'h0000_0000;
        next_st = st;
        // control writes
        if (I_WR)
        begin
            unique case (I_ADDR)
                `ASA_REG_CTRL:
                begin
                    next_st.glob_en = I_WDATA[`ASA_CTRL_GEN];
                    next_st.alert_inv = I_WDATA[`ASA_CTRL_AINV];
                    next_st.alert_on = I_WDATA[`ASA_CTRL_AON];
                    next_st.alert_pin =
                        I_WDATA[`ASA_CTRL_APIN_LSB +: `ASA_PIN_W];
                end
                `ASA_REG_ALERT_EN:
                    next_st.alert_en = I_WDATA[`ASA_N_ALM-1:0];
                `ASA_REG_BLK_EN:
                    next_st.blk_en = I_WDATA[`ASA_N_BLK-1:0];
                default:
                begin
                    if (is_gpio(I_ADDR))
                        next_st.cfg[gpio_idx(I_ADDR)] =
                            I_WDATA[$bits(asa_gpio_cfg_s)-1:0];
                end
            endcase
        end
        // read mux; clear registers and holes read as zero
        if (I_RD)
        begin
            unique case (I_ADDR)
                `ASA_REG_CTRL:
                begin
                    rd[`ASA_CTRL_GEN] = st.glob_en;
                    rd[`ASA_CTRL_AINV] = st.alert_inv;
                    rd[`ASA_CTRL_AON] = st.alert_on;
                    rd[`ASA_CTRL_APIN_LSB +: `ASA_PIN_W] = st.alert_pin;
                end
                `ASA_REG_LIVE:
                    rd[`ASA_N_ALM-1:0] = live;
                `ASA_REG_STICKY:
                    rd[`ASA_N_ALM-1:0] = alm.sticky;
                `ASA_REG_ALERT_EN:
                    rd[`ASA_N_ALM-1:0] = st.alert_en;
                `ASA_REG_BLK_STICKY:
                    rd[`ASA_N_BLK-1:0] = alm.blk_sticky;
                `ASA_REG_BLK_EN:
                    rd[`ASA_N_BLK-1:0] = st.blk_en;
                `ASA_REG_LOOP_STATE:
                    rd[`ASA_N_LOOP*`ASA_ST_W-1:0] = I_LOOP_STATE;
                `ASA_REG_ALERT_STAT:
                    rd[0] = alert;
                default:
                begin
                    if (is_gpio(I_ADDR))
                        rd[$bits(asa_gpio_cfg_s)-1:0] =
                            st.cfg[gpio_idx(I_ADDR)];
                end
            endcase
        end
        // answer stands only in the cycle after the read strobe
        next_st.rdata = rd;
    end

    // state register with documented reset values
    always_ff @(posedge I_CORE_CLK)
    begin
        if (I_SRST)
        begin
            st <= '0;
            st.glob_en <= 1'(`ASA_CTRL_RST >> `ASA_CTRL_GEN);
            st.blk_en <= asa_blk_t'(`ASA_BLK_EN_RST);
        end
        else
        begin
            st <= next_st;
        end
    end

    // sticky change bits and block bits
    asa_sticky_bank u_bank (
        .i_clk(I_CORE_CLK),
        .i_srst(I_SRST),
        .bus(alm.bank),
        .i_blk_en(st.blk_en)
    );

    // pin outputs and the aggregated alert
    asa_pin_drive u_pins (
        .i_clk(I_CORE_CLK),
        .i_srst(I_SRST),
        .bus(alm.pins),
        .i_alert_en(st.alert_en),
        .i_cfg(st.cfg),
        .i_alert_on(st.alert_on),
        .i_alert_inv(st.alert_inv),
        .i_alert_pin(st.alert_pin),
        .o_gpio(O_GPIO),
        .o_gpio_oe(O_GPIO_OE),
        .o_alert(alert)
    );

    assign O_RDATA = st.rdata;
endmodule
`default_nettype wire

// >>> tb/asa_props.sv
/*
 Checker of the aggregator top: read port, live, sticky relations.
 Assumes it is bound onto asa_top, one core clock domain.
*/
`timescale 1ns/10ps
`default_nettype none
module asa_props (
    input wire logic I_CORE_CLK,
    input wire logic I_SRST,
    input wire logic [7:0] I_ADDR,
    input wire logic [31:0] I_WDATA,
    input wire logic I_WR,
    input wire logic I_RD,
    input wire logic [31:0] O_RDATA,
    input wire logic [`ASA_N_REF-1:0] I_REF_FREQ_ALM,
    input wire logic [`ASA_N_REF-1:0] I_REF_LOS_ALM,
    input wire logic [`ASA_N_REF-1:0] I_REF_ACT_ALM,
    input wire logic [`ASA_N_LOOP*`ASA_ST_W-1:0] I_LOOP_STATE,
    input wire logic I_SYS_APLL_LOCKED,
    input wire logic [`ASA_N_GPIO-1:0] O_GPIO,
    input wire logic [`ASA_N_GPIO-1:0] O_GPIO_OE
);
    logic [`ASA_N_LOOP-1:0] hold_v;
    logic [`ASA_N_LOOP-1:0] lock_v;
    logic [`ASA_N_ALM-1:0] seen;
    logic gen_q;
    logic rd_q;
    logic rd_stk;
    logic clr_wr;
    // strobe decodes and expected loop live bits
    always_comb
    begin
        rd_stk = I_RD && I_ADDR == `ASA_REG_STICKY;
        clr_wr = I_WR && I_ADDR == `ASA_REG_STICKY_CLR;
        for (int l = 0; l < `ASA_N_LOOP; l++)
        begin
            hold_v[l] = I_LOOP_STATE[3*l +: 3] == `ASA_LS_HOLDOVER;
            lock_v[l] = I_LOOP_STATE[3*l +: 3] == `ASA_LS_LOCKED
                && I_SYS_APLL_LOCKED;
        end
    end
    // shadow of global enable and of sticky bits already reported
    always_ff @(posedge I_CORE_CLK)
    begin
        if (I_SRST)
        begin
            gen_q <= 1'b0;
            rd_q <= 1'b0;
            seen <= '0;
        end
        else
        begin
            rd_q <= rd_stk;
            if (I_WR && I_ADDR == `ASA_REG_CTRL)
                gen_q <= I_WDATA[`ASA_CTRL_GEN];
            seen <= (rd_q ? O_RDATA[`ASA_N_ALM-1:0] : seen)
                & ~(clr_wr ? I_WDATA[`ASA_N_ALM-1:0] : '0);
        end
    end
    default clocking cb @(posedge I_CORE_CLK);
    endclocking
    default disable iff (I_SRST);
    sequence s_edge;
        gen_q && $changed(I_REF_FREQ_ALM[0]);
    endsequence
    sequence s_race;
        gen_q && $changed(I_REF_FREQ_ALM[0]) && clr_wr && I_WDATA[0];
    endsequence
    chk_rdata_idle: assert property (!$past(I_RD) |-> O_RDATA == 32'h0)
        else $error("read data not zero outside answer cycle");
    chk_live_ref: assert property (I_RD && I_ADDR == `ASA_REG_LIVE
        |=> O_RDATA[11:0] == $past({I_REF_ACT_ALM, I_REF_LOS_ALM,
        I_REF_FREQ_ALM})) else $error("reference live bits wrong");
    chk_live_hold: assert property (I_RD && I_ADDR == `ASA_REG_LIVE
        |=> O_RDATA[16:12] == $past(hold_v)) else $error("holdover live");
    chk_live_lock: assert property (I_RD && I_ADDR == `ASA_REG_LIVE
        |=> O_RDATA[21:17] == $past(lock_v)) else $error("lock live wrong");
    chk_loop_state: assert property (I_RD &&
        I_ADDR == `ASA_REG_LOOP_STATE |=> O_RDATA[14:0] == $past(I_LOOP_STATE))
        else $error("loop state field wrong");
    chk_sticky_set: assert property (s_edge ##1 rd_stk |=> O_RDATA[0])
        else $error("sticky not set on change");
    chk_set_wins: assert property (s_race ##1 !I_WR ##1 rd_stk
        |=> O_RDATA[0]) else $error("clear beat a same cycle set");
    chk_sticky_keep: assert property (rd_stk
        |=> (O_RDATA[`ASA_N_ALM-1:0] & seen) == seen)
        else $error("sticky bit dropped without clear");
endmodule
bind asa_top asa_props chk (.I_CORE_CLK, .I_SRST, .I_ADDR, .I_WDATA,
    .I_WR, .I_RD, .O_RDATA, .I_REF_FREQ_ALM, .I_REF_LOS_ALM, .I_REF_ACT_ALM,
    .I_LOOP_STATE, .I_SYS_APLL_LOCKED, .O_GPIO, .O_GPIO_OE);
`default_nettype wire

// >>> tb/asa_host.sv
/*
 Host model: register port master that polls and services alarms.
 Assumes the core clock and a slave that never waits.
*/
`timescale 1ns/10ps
`default_nettype none
module asa_host (
    input wire logic i_clk,
    input wire logic [31:0] i_rdata,
    output logic [7:0] o_addr,
    output logic [31:0] o_wdata,
    output logic o_wr,
    output logic o_rd
);
    // idle bus at time zero
    initial
    begin
        o_addr = 8'h00;
        o_wdata = 32'h0;
        o_wr = 1'b0;
        o_rd = 1'b0;
    end
    // one-cycle write strobe
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk);
        o_wr <= 1'b1;
        o_addr <= a;
        o_wdata <= d;
        @(posedge i_clk);
        o_wr <= 1'b0;
    endtask
    // one-cycle read strobe, data taken in the following cycle
    task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
        @(posedge i_clk);
        o_rd <= 1'b1;
        o_addr <= a;
        @(posedge i_clk);
        o_rd <= 1'b0;
        @(negedge i_clk);
        d = i_rdata;
    endtask
    // service by polling: alarm bits first, then block bits
    task automatic service(input logic [31:0] alm, input logic [31:0] blk);
        wr_reg(`ASA_REG_STICKY_CLR, alm);
        wr_reg(`ASA_REG_BLK_CLR, blk);
    endtask
endmodule
`default_nettype wire

// >>> tb/tb_alarm_status_aggregator.sv
/*
 Testbench of the aggregator top, driven by the host model.
 Assumes the release hold of the alert is 4000 core clock cycles.
*/
`timescale 1ns/10ps
`default_nettype none
module tb_alarm_status_aggregator;
    localparam logic [7:0] a_ctrl = `ASA_REG_CTRL;
    localparam logic [7:0] a_stk = `ASA_REG_STICKY;
    localparam logic [7:0] a_clr = `ASA_REG_STICKY_CLR;
    localparam logic [7:0] a_bstk = `ASA_REG_BLK_STICKY;
    localparam logic [7:0] a_bclr = `ASA_REG_BLK_CLR;
    localparam logic [7:0] a_gpio = `ASA_REG_GPIO_BASE;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic [3:0] freq = 4'h0;
    logic [3:0] los = 4'h0;
    logic [3:0] act = 4'h0;
    logic [14:0] state = 15'h0;
    logic apll = 1'b0;
    logic [7:0] addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic wr;
    logic rd;
    logic [7:0] gpio;
    logic [7:0] oe;
    int miscompares = 0;
    int total_checks = 0;
    int n;
    // core clock, 50 ns period
    always #25 clk = ~clk;
    asa_host host (.i_clk(clk), .i_rdata(rdata), .o_addr(addr),
        .o_wdata(wdata), .o_wr(wr), .o_rd(rd));
    asa_top uut (.I_CORE_CLK(clk), .I_SRST(srst), .I_ADDR(addr),
        .I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .O_RDATA(rdata),
        .I_REF_FREQ_ALM(freq), .I_REF_LOS_ALM(los), .I_REF_ACT_ALM(act),
        .I_LOOP_STATE(state), .I_SYS_APLL_LOCKED(apll), .O_GPIO(gpio),
        .O_GPIO_OE(oe));
    // compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("unexpected at %0t: got %h, want %h", $time, got, exp);
        end
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] d;
        host.rd_reg(a, d);
        chk(d, e);
    endtask
    task automatic settle;
        repeat (4) @(negedge clk);
    endtask
    task automatic end_sim;
        $display("checks %0d, mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic t_reset;
        rdc(a_ctrl, `ASA_CTRL_RST);
        rdc(`ASA_REG_BLK_EN, `ASA_BLK_EN_RST);
        rdc(a_stk, 32'h0);
        chk({24'h0, oe}, 32'h0);
        $display("test reset done");
    endtask
    task automatic t_live;
        @(posedge clk);
        {act, los, freq} <= 12'h3a5;
        state <= {3'h4, 3'h3, 3'h3, 3'h0, 3'h4};
        apll <= 1'b1;
        rdc(`ASA_REG_LIVE, {10'h0, 5'b01100, 5'b10001, 12'h3a5});
        rdc(`ASA_REG_LOOP_STATE, {17'h0, state});
        @(posedge clk);
        apll <= 1'b0;
        rdc(`ASA_REG_LIVE, {15'h0, 5'b10001, 12'h3a5});
        @(posedge clk);
        {act, los, freq} <= 12'h0;
        state <= 15'h0;
        apll <= 1'b1;
        rdc(a_stk, 32'h0);
        $display("test live done");
    endtask
    task automatic t_sticky;
        host.wr_reg(a_ctrl, 32'h1);
        @(posedge clk);
        freq[0] <= 1'b1;
        rdc(a_stk, 32'h1);
        host.wr_reg(a_clr, 32'h0);
        rdc(a_stk, 32'h1);
        host.wr_reg(a_clr, 32'h1);
        rdc(a_stk, 32'h0);
        @(posedge clk);
        freq[0] <= 1'b0;
        rdc(a_stk, 32'h1);
        fork
            host.wr_reg(a_clr, 32'h1);
            begin
                @(posedge clk);
                freq[0] <= 1'b1;
            end
        join
        rdc(a_stk, 32'h1);
        @(posedge clk);
        los[0] <= 1'b1;
        act[0] <= 1'b1;
        host.wr_reg(a_clr, 32'h11);
        rdc(a_stk, 32'h100);
        host.wr_reg(a_bclr, 32'h1);
        rdc(a_bstk, 32'h1);
        host.service(32'h3f_ffff, 32'h1);
        rdc(a_stk, 32'h0);
        rdc(a_bstk, 32'h0);
        // a disabled block loses its changes
        host.wr_reg(`ASA_REG_BLK_EN, 32'h1fe);
        @(posedge clk);
        act[0] <= 1'b0;
        rdc(a_stk, 32'h0);
        host.wr_reg(`ASA_REG_BLK_EN, `ASA_BLK_EN_RST);
        $display("test sticky done");
    endtask
    task automatic t_pin;
        host.wr_reg(a_gpio + 8'h04, 32'h84);
        settle;
        chk({30'h0, gpio[1], oe[1]}, 32'h3);
        @(posedge clk);
        los[0] <= 1'b0;
        settle;
        chk({31'h0, gpio[1]}, 32'h0);
        host.wr_reg(a_gpio + 8'h04, 32'hc4);
        settle;
        chk({31'h0, gpio[1]}, 32'h1);
        host.wr_reg(a_gpio + 8'h08, 32'hac);
        @(posedge clk);
        state[2:0] <= 3'h4;
        @(posedge clk);
        state[2:0] <= 3'h0;
        settle;
        chk({31'h0, gpio[2]}, 32'h1);
        host.wr_reg(a_clr, 32'h1000);
        settle;
        chk({31'h0, gpio[2]}, 32'h0);
        $display("test pin done");
    endtask
    task automatic t_alert;
        host.service(32'h3f_ffff, 32'h1ff);
        host.wr_reg(`ASA_REG_ALERT_EN, 32'h1);
        host.wr_reg(a_ctrl, 32'h35);
        settle;
        chk({30'h0, gpio[3], oe[3]}, 32'h1);
        @(posedge clk);
        los[1] <= 1'b1;
        settle;
        chk({31'h0, gpio[3]}, 32'h0);
        @(posedge clk);
        freq[0] <= 1'b0;
        settle;
        chk({31'h0, gpio[3]}, 32'h1);
        rdc(`ASA_REG_ALERT_STAT, 32'h1);
        host.wr_reg(a_ctrl, 32'h37);
        settle;
        chk({31'h0, gpio[3]}, 32'h0);
        host.wr_reg(a_ctrl, 32'h35);
        host.wr_reg(a_clr, 32'h1);
        repeat (4010) @(negedge clk);
        chk({31'h0, gpio[3]}, 32'h1);
        host.service(32'h3f_ffff, 32'h1ff);
        n = 0;
        // pin must fall within the release time of the block clear
        while (gpio[3] !== 1'b0 && n < 4001)
        begin
            @(negedge clk);
            n++;
        end
        chk({31'h0, gpio[3]}, 32'h0);
        $display("test alert done");
    endtask
    // watchdog against a hang
    initial
    begin
        repeat (20000) @(posedge clk);
        miscompares++;
        end_sim;
    end
    // reset, then the scenarios in order
    initial
    begin
        repeat (20) @(posedge clk);
        srst <= 1'b0;
        t_reset;
        t_live;
        t_sticky;
        t_pin;
        t_alert;
        end_sim;
    end
endmodule
`default_nettype wire
